/* File: core/frs_encoder.sv */
// Result status encoder: builds status bytes 0 and 1 and serves them on reads.
// Assumes controller events are single-cycle pulses on mclk; drive pins are async.
//
// Notes on behaviour
// - Result phase returns status bytes in order
// - Termination code 00 on clean completion
// - Code 01 when started but failed
// - Code 10 for an invalid command
// - Code 11 for abort by drive polling
// - Seek done flag after seek commands
// - Track zero fault after 80 recalibrate steps
// - Track zero fault stepping outward past zero
// - Unused status bits always read zero
// - Head address of the reported command
// - Selected drive code in low bits
// - End of track flag, incl. no count
// - CRC fault on ID or data field
// - Overrun or underrun when service late
// - No data when read sector missing
// - No data on failed ID read
// - No data on bad track sequence
// - Write blocked when protect is high while writing
// - Missing mark after two index pulses
// - Missing mark when data mark absent
// - Data register sits at offset five
`timescale 1ns/10ps
module frs_encoder #(
  parameter int STEP_LIMIT = frs_pkg::FRS_STEP_LIMIT
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic cmdStart,
  input wire frs_pkg::frs_cmd_t cmdKind,
  input wire logic headSel,
  input wire logic [1:0] driveSel,
  input wire logic invalidCmd,
  input wire logic pollAbort,
  input wire logic execDone,
  input wire logic stepPulse,
  input wire logic stepOutward,
  input wire logic idMarkFound,
  input wire logic dataMarkMissing,
  input wire logic crcFault,
  input wire logic overrunEvt,
  input wire logic sectorMissing,
  input wire logic idReadFail,
  input wire logic seqFault,
  input wire logic pastLastSector,
  input wire logic endWithoutTc,
  input wire logic trackZeroPin,
  input wire logic indexPin,
  input wire logic writeProtectPin,
  input wire logic resultStart,
  input wire logic [2:0] hostAddr,
  input wire logic hostRd,
  output logic [7:0] hostDout,
  output logic resultPhase,
  output logic [7:0] resultStatusZero,
  output logic [7:0] resultStatusOne
);
  import frs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; logic reads the second stage, plus a third stage for index edges
  logic tzMeta, tzSync, idxMeta, idxSync, idxPrev, wpMeta, wpSync;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tzMeta <= 1'b0;
      tzSync <= 1'b0;
      idxMeta <= 1'b0;
      idxSync <= 1'b0;
      idxPrev <= 1'b0;
      wpMeta <= 1'b0;
      wpSync <= 1'b0;
    end else if (ce) begin
      tzMeta <= trackZeroPin;
      tzSync <= tzMeta;
      idxMeta <= indexPin;
      idxSync <= idxMeta;
      idxPrev <= idxSync;
      wpMeta <= writeProtectPin;
      wpSync <= wpMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command classes
  function automatic logic isSeekCmd(input frs_cmd_t k);
    return (k == FRS_CMD_SEEK) || (k == FRS_CMD_REL_SEEK) || (k == FRS_CMD_RECAL);
  endfunction
  function automatic logic isWriteCmd(input frs_cmd_t k);
    return (k == FRS_CMD_WRITE_DATA) || (k == FRS_CMD_WRITE_DEL) || (k == FRS_CMD_FORMAT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing and host read port
  frs_state_t state, next_state;
  logic [7:0] next_hostDout;
  logic next_resultPhase;
  logic rdHit;
  assign rdHit = hostRd && (hostAddr == FRS_DATA_OFFSET);
  always_comb begin
    next_state = state;
    next_hostDout = hostDout;
    next_resultPhase = resultPhase;
    if (cmdStart) begin
      next_state = FRS_EXEC;
      next_resultPhase = 1'b0;
    end else begin
      unique case (state)
        FRS_IDLE: next_state = FRS_IDLE;
        FRS_EXEC: begin
          if (resultStart) begin
            next_state = FRS_RES0;
            next_resultPhase = 1'b1;
          end
        end
        FRS_RES0: begin
          if (rdHit) begin
            next_hostDout = resultStatusZero;
            next_state = FRS_RES1;
          end
        end
        FRS_RES1: begin
          if (rdHit) begin
            next_hostDout = resultStatusOne;
            next_state = FRS_IDLE;
            next_resultPhase = 1'b0;
          end
        end
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= FRS_IDLE;
      hostDout <= FRS_BYTE_RESET;
      resultPhase <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      hostDout <= next_hostDout;
      resultPhase <= next_resultPhase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step and index counters
  logic [6:0] stepCount, next_stepCount;
  logic [1:0] idxCount, next_idxCount;
  logic idxRise, inExec, recalFail, pastZero, idxExhausted;
  assign inExec = (state == FRS_EXEC) && !cmdStart;
  assign idxRise = idxSync && !idxPrev;
  // last allowed step with no track zero
  assign recalFail = inExec && (cmdKind == FRS_CMD_RECAL) && stepPulse && !tzSync
                     && (stepCount == 7'(STEP_LIMIT - 1));
  // outward step already at track zero
  assign pastZero = inExec && (cmdKind == FRS_CMD_REL_SEEK) && stepPulse
                    && stepOutward && tzSync;
  // second index without an ID mark
  assign idxExhausted = inExec && idxRise && !idMarkFound
                        && (idxCount == 2'(FRS_INDEX_LIMIT - 1));
  always_comb begin
    next_stepCount = stepCount;
    next_idxCount = idxCount;
    if (cmdStart) begin
      next_stepCount = 7'h00;
      next_idxCount = 2'h0;
    end else if (inExec) begin
      if (stepPulse && (stepCount != 7'(STEP_LIMIT))) begin
        next_stepCount = stepCount + 7'h01;
      end
      if (idMarkFound) begin
        next_idxCount = 2'h0;
      end else if (idxRise && (idxCount != 2'(FRS_INDEX_LIMIT))) begin
        next_idxCount = idxCount + 2'h1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stepCount <= 7'h00;
      idxCount <= 2'h0;
    end else if (ce) begin
      stepCount <= next_stepCount;
      idxCount <= next_idxCount;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; the clear wins over a set in the clearing cycle
  logic [1:0] termCode, next_termCode;
  logic seekDone, trkFault, headBit, endCyl, crcBad, ovr, noData, wrBlk, markMiss;
  logic [1:0] drvCode;
  logic next_seekDone, next_trkFault, next_headBit, next_endCyl, next_crcBad;
  logic next_ovr, next_noData, next_wrBlk, next_markMiss;
  logic [1:0] next_drvCode;
  always_comb begin
    next_termCode = cmdStart ? FRS_TERM_NORMAL : termCode;
    next_seekDone = cmdStart ? 1'b0 : seekDone;
    next_trkFault = cmdStart ? 1'b0 : trkFault;
    next_endCyl = cmdStart ? 1'b0 : endCyl;
    next_crcBad = cmdStart ? 1'b0 : crcBad;
    next_ovr = cmdStart ? 1'b0 : ovr;
    next_noData = cmdStart ? 1'b0 : noData;
    next_wrBlk = cmdStart ? 1'b0 : wrBlk;
    next_markMiss = cmdStart ? 1'b0 : markMiss;
    next_headBit = cmdStart ? headSel : headBit;
    next_drvCode = cmdStart ? driveSel : drvCode;
    if (inExec) begin
      next_trkFault = next_trkFault | recalFail | pastZero;
      next_endCyl = next_endCyl | pastLastSector | endWithoutTc;
      next_crcBad = next_crcBad | crcFault;
      next_ovr = next_ovr | overrunEvt;
      next_noData = next_noData | sectorMissing | idReadFail | seqFault;
      next_wrBlk = next_wrBlk | (wpSync && isWriteCmd(cmdKind));
      next_markMiss = next_markMiss | idxExhausted | dataMarkMissing;
      next_seekDone = next_seekDone | (execDone && isSeekCmd(cmdKind));
      if (pollAbort) begin
        next_termCode = FRS_TERM_POLL;
      end else if (invalidCmd) begin
        next_termCode = FRS_TERM_INVALID;
      end else if (execDone && (termCode == FRS_TERM_NORMAL)
                   && (next_trkFault | next_endCyl | next_crcBad | next_ovr
                       | next_noData | next_wrBlk | next_markMiss)) begin
        next_termCode = FRS_TERM_ABNORMAL;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      termCode <= FRS_TERM_NORMAL;
      {seekDone, trkFault, headBit, endCyl, crcBad} <= 5'h00;
      {ovr, noData, wrBlk, markMiss} <= 4'h0;
      drvCode <= 2'h0;
    end else if (ce) begin
      termCode <= next_termCode;
      seekDone <= next_seekDone;
      trkFault <= next_trkFault;
      headBit <= next_headBit;
      drvCode <= next_drvCode;
      endCyl <= next_endCyl;
      crcBad <= next_crcBad;
      ovr <= next_ovr;
      noData <= next_noData;
      wrBlk <= next_wrBlk;
      markMiss <= next_markMiss;
    end
  end

  assign resultStatusZero = {termCode, seekDone, trkFault, 1'b0, headBit, drvCode};
  assign resultStatusOne = {endCyl, 1'b0, crcBad, ovr, 1'b0, noData, wrBlk, markMiss};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_readFirst;
    ce && (state == FRS_RES0) && rdHit && !cmdStart;
  endsequence
  sequence s_readSecond;
    ce && (state == FRS_RES1) && rdHit && !cmdStart;
  endsequence
  property p_readOrder;
    s_readSecond |=> (hostDout == resultStatusOne) && !resultPhase && (state == FRS_IDLE);
  endproperty
  a_readOrder: assert property (p_readOrder) else $error("second read not byte 1");
  property p_readZero;
    s_readFirst |=> (hostDout == resultStatusZero) && (state == FRS_RES1);
  endproperty
  a_readZero: assert property (p_readZero) else $error("first read not byte 0");
  property p_cleanEnd;
    ce && inExec && execDone && !pollAbort && !invalidCmd && (termCode == FRS_TERM_NORMAL)
      && (resultStatusOne == FRS_BYTE_RESET) && !trkFault && !crcFault && !overrunEvt
      && !sectorMissing && !idReadFail && !seqFault && !pastLastSector && !endWithoutTc
      && !dataMarkMissing && !idxExhausted && !recalFail && !pastZero
      && !(wpSync && isWriteCmd(cmdKind)) |=> termCode == FRS_TERM_NORMAL;
  endproperty
  a_cleanEnd: assert property (p_cleanEnd) else $error("clean command not 00");
  property p_abnormal;
    ce && inExec && execDone && crcFault && !pollAbort && !invalidCmd
      && (termCode == FRS_TERM_NORMAL) |=> termCode == FRS_TERM_ABNORMAL;
  endproperty
  a_abnormal: assert property (p_abnormal) else $error("failed command not 01");
  property p_invalid;
    ce && inExec && invalidCmd && !pollAbort |=> termCode == FRS_TERM_INVALID;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid command not 10");
  property p_poll;
    ce && inExec && pollAbort |=> resultStatusZero[7:6] == FRS_TERM_POLL;
  endproperty
  a_poll: assert property (p_poll) else $error("poll abort not 11");
  property p_seekDone;
    ce && inExec && execDone && isSeekCmd(cmdKind) |=> resultStatusZero[FRS_ST0_SEEK];
  endproperty
  a_seekDone: assert property (p_seekDone) else $error("seek done not set");
  property p_recalFault;
    ce && recalFail |=> resultStatusZero[FRS_ST0_TRACK_ZERO_INPUT] && (stepCount == 7'(STEP_LIMIT));
  endproperty
  a_recalFault: assert property (p_recalFault) else $error("recal fault missing");
  property p_unused;
    !resultStatusZero[3] && !resultStatusOne[6] && !resultStatusOne[3];
  endproperty
  a_unused: assert property (p_unused) else $error("unused status bit set");
  property p_clearStart;
    ce && cmdStart |=> (resultStatusOne == FRS_BYTE_RESET)
      && (resultStatusZero[5:0] == {3'h0, $past(headSel), $past(driveSel)});
  endproperty
  a_clearStart: assert property (p_clearStart) else $error("flags not cleared");
  property p_writeBlock;
    ce && inExec && wpSync && isWriteCmd(cmdKind) |=> resultStatusOne[FRS_ST1_WPROT];
  endproperty
  a_writeBlock: assert property (p_writeBlock) else $error("protect not flagged");
  property p_indexMark;
    ce && idxExhausted |=> resultStatusOne[FRS_ST1_MARK];
  endproperty
  a_indexMark: assert property (p_indexMark) else $error("missing mark not set");
endmodule

/* File: dv/frs_host_model.sv */
// Host side model: reads result bytes through the data port.
// Assumes one mclk domain; the bench tells it when and where to read.
`timescale 1ns/10ps
module frs_host_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] hostDout,
  input wire logic readGo,
  input wire logic [1:0] readCount,
  input wire logic [2:0] readAddr,
  input wire logic [1:0] readGap,
  output logic [2:0] hostAddr,
  output logic hostRd,
  output logic byteSeen,
  output logic [7:0] byteVal
);
  logic [1:0] left;
  logic [1:0] gapCnt;
  logic pend;
  ////////////////////////////////////////////////////////////////
  // Read data is settled one edge after the taken strobe
  assign byteSeen = pend;
  assign byteVal = hostDout;
  always @(posedge mclk) begin
    pend <= hostRd;
    if (!resetn) begin
      hostAddr <= #1 3'h0;
      left <= 2'h0;
      gapCnt <= 2'h0;
      hostRd <= #1 1'b0;
    end else if (readGo) begin
      left <= readCount;
      gapCnt <= 2'h0;
      hostRd <= #1 1'b0;
    end else if (left != 2'h0 && gapCnt == 2'h0) begin
      hostRd <= #1 1'b1;
      hostAddr <= #1 readAddr;
      left <= left - 2'h1;
      gapCnt <= readGap;
    end else begin
      // Idle address wanders, never a stale copy
      hostRd <= #1 1'b0;
      hostAddr <= #1 hostAddr + 3'h1;
      if (gapCnt != 2'h0) gapCnt <= gapCnt - 2'h1;
    end
  end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the result status encoder.
// Assumes the host model as reader; step limit shrunk to keep runs short.
`timescale 1ns/10ps
module testbench;
  import frs_pkg::*;
  localparam int STEPS = 4;
  localparam logic [7:0] EV_ONE [8] = '{8'h01, 8'h20, 8'h10, 8'h04, 8'h04, 8'h04, 8'h80, 8'h80};
  localparam frs_cmd_t EV_KIND [8] = '{FRS_CMD_READ_DATA, FRS_CMD_READ_DATA,
    FRS_CMD_WRITE_DATA, FRS_CMD_READ_DEL, FRS_CMD_READ_ID, FRS_CMD_READ_TRACK,
    FRS_CMD_READ_DATA, FRS_CMD_WRITE_DATA};
  logic mclk, resetn, ce, cmdStart, headSel, invalidCmd, pollAbort, execDone;
  logic stepPulse, stepOutward, idMarkFound, trackZeroPin, indexPin, writeProtectPin;
  logic resultStart, hostRd, resultPhase, readGo, byteSeen;
  frs_cmd_t cmdKind;
  logic [1:0] driveSel, readCount, readGap;
  logic [7:0] evBus, hostDout, byteVal, lastByte, statusZero, statusOne;
  logic [2:0] hostAddr, readAddr;
  logic [31:0] rnd;
  logic [7:0] expQ [$];
  int num_errors, check_count, i;
  ////////////////////////////////////////////////////////////////
  frs_encoder #(.STEP_LIMIT(STEPS)) frs_encoder_i (.mclk(mclk), .resetn(resetn), .ce(ce),
    .cmdStart(cmdStart), .cmdKind(cmdKind), .headSel(headSel), .driveSel(driveSel),
    .invalidCmd(invalidCmd), .pollAbort(pollAbort), .execDone(execDone),
    .stepPulse(stepPulse), .stepOutward(stepOutward), .idMarkFound(idMarkFound),
    .dataMarkMissing(evBus[7]), .crcFault(evBus[6]), .overrunEvt(evBus[5]),
    .sectorMissing(evBus[4]), .idReadFail(evBus[3]), .seqFault(evBus[2]),
    .pastLastSector(evBus[1]), .endWithoutTc(evBus[0]), .trackZeroPin(trackZeroPin),
    .indexPin(indexPin), .writeProtectPin(writeProtectPin), .resultStart(resultStart),
    .hostAddr(hostAddr), .hostRd(hostRd), .hostDout(hostDout), .resultPhase(resultPhase),
    .resultStatusZero(statusZero), .resultStatusOne(statusOne));
  frs_host_model frs_host_model_i (.mclk(mclk), .resetn(resetn), .hostDout(hostDout),
    .readGo(readGo), .readCount(readCount), .readAddr(readAddr), .readGap(readGap),
    .hostAddr(hostAddr), .hostRd(hostRd), .byteSeen(byteSeen), .byteVal(byteVal));
  ////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Oldest note is paired with each byte the host sees
  always @(posedge mclk) begin
    if (byteSeen === 1'b1) begin
      if (expQ.size() > 0) check(byteVal, expQ.pop_front());
      else check({byteSeen, 7'h00}, 8'h00);
    end
  end
  ////////////////////////////////////////////////////////////////
  // One command, result phase and reads; fin 0 done, 1 invalid, 2 poll
  task automatic cmd(input frs_cmd_t k, input logic [7:0] ev, input int steps, input int idx,
      input int fin, input logic [1:0] tc, input logic sk, input logic eck,
      input logic [7:0] e1, input logic bad);
    int n;
    logic [7:0] e0;
    rnd = lfsr(rnd);
    cmdStart = 1'b1;
    cmdKind = k;
    headSel = rnd[0];
    driveSel = rnd[2:1];
    readGap = rnd[4:3];
    e0 = {tc, sk, eck, 1'b0, rnd[0], rnd[2:1]};
    tick;
    cmdStart = 1'b0;
    // Inputs move on; latched head and drive must hold
    headSel = rnd[5];
    driveSel = rnd[7:6];
    idMarkFound = (idx == 0);
    evBus = ev;
    tick;
    idMarkFound = 1'b0;
    evBus = 8'h00;
    repeat (4) tick;
    for (n = 0; n < steps; n++) begin
      stepPulse = 1'b1;
      tick;
      stepPulse = 1'b0;
      tick;
    end
    for (n = 0; n < idx * 6; n++) begin
      indexPin = (n % 6) < 3;
      tick;
    end
    indexPin = 1'b0;
    repeat (3) tick;
    execDone = (fin == 0);
    invalidCmd = (fin == 1);
    pollAbort = (fin == 2);
    tick;
    {execDone, invalidCmd, pollAbort} = 3'h0;
    resultStart = 1'b1;
    tick;
    resultStart = 1'b0;
    check({7'h00, resultPhase}, 8'h01);
    check(statusZero, e0);
    check(statusOne, e1);
    // Off-port read is refused, old data stays
    if (bad) begin
      expQ.push_back(lastByte);
      readAddr = 3'h3;
      readCount = 2'h1;
      readGo = 1'b1;
      tick;
      readGo = 1'b0;
      repeat (4) tick;
    end
    expQ.push_back(e0);
    expQ.push_back(e1);
    readAddr = FRS_DATA_OFFSET;
    readCount = 2'h2;
    readGo = 1'b1;
    tick;
    readGo = 1'b0;
    n = 0;
    while ((expQ.size() != 0 || resultPhase !== 1'b0) && n < 80) begin
      tick;
      n++;
    end
    if (expQ.size() != 0 || resultPhase !== 1'b0) begin
      num_errors++;
      wrap_up;
    end
    lastByte = e1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {resetn, cmdStart, headSel, invalidCmd, pollAbort, execDone, stepPulse} = 7'h00;
    {idMarkFound, trackZeroPin, indexPin, writeProtectPin, resultStart, readGo} = 6'h00;
    {driveSel, readCount, readGap, evBus, readAddr, lastByte} = 25'h0;
    {ce, stepOutward} = 2'h3;
    cmdKind = FRS_CMD_OTHER;
    rnd = 32'h652D413A;
    num_errors = 0;
    check_count = 0;
    repeat (12) @(posedge mclk);
    #1 resetn = 1'b1;
    cmd(FRS_CMD_READ_DATA, 8'h00, 0, 0, 0, FRS_TERM_NORMAL, 1'b0, 1'b0, 8'h00, 1'b1);
    for (i = 0; i < 8; i++) begin
      cmd(EV_KIND[i], 8'h80 >> i, 0, 0, 0, FRS_TERM_ABNORMAL, 1'b0, 1'b0, EV_ONE[i], i == 3);
    end
    cmd(FRS_CMD_OTHER, 8'h00, 0, 0, 1, FRS_TERM_INVALID, 1'b0, 1'b0, 8'h00, 1'b0);
    cmd(FRS_CMD_READ_DATA, 8'h00, 0, 0, 2, FRS_TERM_POLL, 1'b0, 1'b0, 8'h00, 1'b0);
    // seek end and step limit edge
    cmd(FRS_CMD_SEEK, 8'h00, 1, 0, 0, FRS_TERM_NORMAL, 1'b1, 1'b0, 8'h00, 1'b0);
    cmd(FRS_CMD_RECAL, 8'h00, STEPS - 1, 0, 0, FRS_TERM_NORMAL, 1'b1, 1'b0, 8'h00, 1'b0);
    cmd(FRS_CMD_RECAL, 8'h00, STEPS, 0, 0, FRS_TERM_ABNORMAL, 1'b1, 1'b1, 8'h00, 1'b0);
    trackZeroPin = 1'b1;
    cmd(FRS_CMD_REL_SEEK, 8'h00, 1, 0, 0, FRS_TERM_ABNORMAL, 1'b1, 1'b1, 8'h00, 1'b0);
    trackZeroPin = 1'b0;
    writeProtectPin = 1'b1;
    cmd(FRS_CMD_WRITE_DATA, 8'h00, 0, 0, 0, FRS_TERM_ABNORMAL, 1'b0, 1'b0, 8'h02, 1'b0);
    writeProtectPin = 1'b0;
    cmd(FRS_CMD_READ_ID, 8'h00, 0, 2, 0, FRS_TERM_ABNORMAL, 1'b0, 1'b0, 8'h01, 1'b0);
    wrap_up;
  end
endmodule

/* File: inc/frs_pkg.sv */
// Shared constants for the floppy result status encoder.
// Assumes one controller clock domain; bytes are read through the data port.
package frs_pkg;
  // Host register offsets
  localparam logic [2:0] FRS_DATA_OFFSET = 3'h5;
  // Status byte 0 field positions
  localparam int FRS_ST0_TERM_HI = 7;
  localparam int FRS_ST0_TERM_LO = 6;
  localparam int FRS_ST0_SEEK = 5;
  localparam int FRS_ST0_TRACK_ZERO_INPUT = 4;
  localparam int FRS_ST0_HEAD = 2;
  localparam int FRS_ST0_DRV_HI = 1;
  // Status byte 1 field positions
  localparam int FRS_ST1_ENDCYL = 7;
  localparam int FRS_ST1_CRC = 5;
  localparam int FRS_ST1_OVR = 4;
  localparam int FRS_ST1_NODATA = 2;
  localparam int FRS_ST1_WPROT = 1;
  localparam int FRS_ST1_MARK = 0;
  // Termination codes
  localparam logic [1:0] FRS_TERM_NORMAL = 2'h0;
  localparam logic [1:0] FRS_TERM_ABNORMAL = 2'h1;
  localparam logic [1:0] FRS_TERM_INVALID = 2'h2;
  localparam logic [1:0] FRS_TERM_POLL = 2'h3;
  // Reset values and limits
  localparam logic [7:0] FRS_BYTE_RESET = 8'h00;
  localparam int FRS_STEP_LIMIT = 80;
  localparam int FRS_INDEX_LIMIT = 2;
  typedef enum logic [3:0] {
    FRS_CMD_READ_DATA = 4'h0, FRS_CMD_READ_DEL = 4'h1, FRS_CMD_WRITE_DATA = 4'h2,
    FRS_CMD_WRITE_DEL = 4'h3, FRS_CMD_READ_TRACK = 4'h4, FRS_CMD_READ_ID = 4'h5,
    FRS_CMD_FORMAT = 4'h6, FRS_CMD_RECAL = 4'h7, FRS_CMD_SEEK = 4'h8,
    FRS_CMD_REL_SEEK = 4'h9, FRS_CMD_OTHER = 4'hF
  } frs_cmd_t;
  // Gray order along idle, execute, first byte, second byte
  typedef enum logic [1:0] {
    FRS_IDLE = 2'h0, FRS_EXEC = 2'h1, FRS_RES0 = 2'h3, FRS_RES1 = 2'h2
  } frs_state_t;
endpackage
